// [hdl/fcs_consts.svh]
// Constants of the flash command and status unit: offsets, fields, key, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Register bus
`define FCS_AW          12
`define FCS_DW          32
`define FCS_OFF_TARGET  12'h000
`define FCS_OFF_WORD    12'h004
`define FCS_OFF_CMD     12'h008
`define FCS_OFF_RAW     12'h00C
`define FCS_OFF_MASK    12'h010
`define FCS_OFF_MSTS    12'h014

// Command register fields
`define FCS_KEY         16'hA442
`define FCS_KEY_HI      31
`define FCS_KEY_LO      16
`define FCS_CMD_W       4
`define FCS_CMD_WORD    0
`define FCS_CMD_PAGE    1
`define FCS_CMD_MASS    2
`define FCS_CMD_COMMIT  3

// Event fields
`define FCS_EVT_W       2
`define FCS_EVT_VIOL    0
`define FCS_EVT_DONE    1

// Target location width
`define FCS_TGT_W       15

// Timing: clock rate and longest operation times as printed
`define FCS_CLK_MHZ     250
`define FCS_T_WORD_US   50
`define FCS_T_COMMIT_US 50
`define FCS_T_PAGE_MS   25
`define FCS_T_MASS_MS   250
`define FCS_US_PER_MS   1000
`define FCS_CNT_W       32
`define FCS_CNT_ONE     32'h00000001

`endif

// [hdl/fcs_pkg.sv]
// Types shared by the flash command and status unit.
// Assumes fcs_consts.svh is on the include path.
`include "fcs_consts.svh"

package fcs_pkg;

  // Operation kinds carried out by the sequencer
  typedef enum logic [2:0] {FCS_OP_NONE, FCS_OP_WORD, FCS_OP_PAGE, FCS_OP_MASS, FCS_OP_COMMIT} fcs_op_t;

  // Sequencer states
  typedef enum logic {FCS_IDLE, FCS_BUSY} fcs_state_t;

  // One register bus request
  typedef struct packed {
    logic [`FCS_AW-1:0] addr;
    logic [`FCS_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } fcs_bus_req_t;

  // Operation handed to the flash array
  typedef struct packed {
    logic                  busy;
    fcs_op_t               kind;
    logic [`FCS_TGT_W-1:0] target;
    logic [`FCS_DW-1:0]    word;
  } fcs_flash_op_t;

endpackage

// [hdl/fcs_op_timer.sv]
// Down counter that times one flash operation for a loaded number of cycles.
// Assumes start_in only while idle and a length of at least one cycle.
`timescale 1ns/1ps
`include "fcs_consts.svh"

module fcs_op_timer
  import fcs_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  start_in,
  input  wire logic [`FCS_CNT_W-1:0] len_in,
  output logic                       done_out
);

  logic [`FCS_CNT_W-1:0] cnt_q;
  logic [`FCS_CNT_W-1:0] cnt_d;
  logic                  run_q;
  logic                  run_d;

  // Last busy cycle is the one where the count reaches one
  assign done_out = run_q & (cnt_q == `FCS_CNT_ONE);
  assign run_d    = start_in | (run_q & ~done_out);
  assign cnt_d    = start_in ? len_in : (run_q ? cnt_q - `FCS_CNT_ONE : cnt_q);

  // Counter state
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

endmodule

// [hdl/fcs_event_flag.sv]
// Sticky event flag: hardware sets, software clears by writing one.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps

module fcs_event_flag
  import fcs_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  logic flag_q;
  logic flag_d;

  // Set wins over clear so a same-cycle event is never lost
  assign flag_d   = set_in | (flag_q & ~clr_in);
  assign flag_out = flag_q;

  // Flag storage
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

endmodule

// [hdl/fcs_command_status.sv]
// Command and status logic of an on-chip flash controller: keyed command register,
// busy readback, raw and masked event flags and the interrupt request.
// Assumes a single-cycle register port and a protection checker on the same clock.
//
// Summary of operation
// - Command writes carry a key in bits 31:16; only the right key acts.
// - A command write with a wrong key is ignored entirely.
// - The key field of the command register always reads as zero.
// - Command bit 3 commits protection settings, lasting up to 50 us.
// - Bit 3 reads one while the commit runs, zero after.
// - Command bit 2 erases the whole array, lasting up to 250 ms.
// - Bit 2 reads one during the full erase, zero after.
// - Command bit 1 erases the page at the target location, up to 25 ms.
// - Bit 1 reads one during the page erase, zero after.
// - Command bit 0 programs the data word at the target, up to 50 us.
// - Bit 0 reads one while programming, zero after.
// - Raw event bit 1 sets when a programming cycle completes.
// - Completion is raised for both program and erase operations.
// - Raw event bit 0 sets on an access against the protection policy.
// - The interrupt is raised only for events whose mask bit is set.
// - Writing one to a masked status bit clears it and its raw flag.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "fcs_consts.svh"

module fcs_command_status
  import fcs_pkg::*;
#(
  parameter logic [`FCS_CNT_W-1:0] WORD_CYCLES   = `FCS_T_WORD_US * `FCS_CLK_MHZ,
  parameter logic [`FCS_CNT_W-1:0] COMMIT_CYCLES = `FCS_T_COMMIT_US * `FCS_CLK_MHZ,
  parameter logic [`FCS_CNT_W-1:0] PAGE_CYCLES   = `FCS_T_PAGE_MS * `FCS_US_PER_MS * `FCS_CLK_MHZ,
  parameter logic [`FCS_CNT_W-1:0] MASS_CYCLES   = `FCS_T_MASS_MS * `FCS_US_PER_MS * `FCS_CLK_MHZ
)
(
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire fcs_bus_req_t  bus_req_in,
  output logic [`FCS_DW-1:0] rd_data_out,
  input  wire logic          access_violation_in,
  output fcs_flash_op_t      flash_op_out,
  output logic               irq_out
);

  // Address match, shared by the write and read decode
  function automatic logic fcs_hit(input logic [`FCS_AW-1:0] a, input logic [`FCS_AW-1:0] off);
    return a == off;
  endfunction

  // One command bit to an operation; lowest bit first when software sets several
  function automatic fcs_op_t fcs_pick(input logic [`FCS_CMD_W-1:0] c);
    fcs_op_t k;
    k = FCS_OP_NONE;
    if (c[`FCS_CMD_WORD])
      k = FCS_OP_WORD;
    else if (c[`FCS_CMD_PAGE])
      k = FCS_OP_PAGE;
    else if (c[`FCS_CMD_MASS])
      k = FCS_OP_MASS;
    else if (c[`FCS_CMD_COMMIT])
      k = FCS_OP_COMMIT;
    return k;
  endfunction

  fcs_state_t            state_q;
  fcs_state_t            state_d;
  fcs_op_t               kind_q;
  fcs_op_t               new_op;
  logic [`FCS_TGT_W-1:0] target_q;
  logic [`FCS_DW-1:0]    word_q;
  logic [`FCS_EVT_W-1:0] mask_q;
  logic [`FCS_EVT_W-1:0] raw_flags;
  logic [`FCS_EVT_W-1:0] evt_set;
  logic [`FCS_EVT_W-1:0] evt_clr;
  logic [`FCS_CMD_W-1:0] cmd_busy;
  logic [`FCS_DW-1:0]    rd_d;
  logic [`FCS_DW-1:0]    rd_data_q;
  logic [`FCS_CNT_W-1:0] op_len;
  logic [`FCS_CNT_W-1:0] cur_len_q;
  logic [`FCS_CNT_W-1:0] busy_cnt_q;
  fcs_flash_op_t         op_q;
  logic                  irq_q;
  logic                  wr_target;
  logic                  wr_word;
  logic                  wr_cmd;
  logic                  wr_mask;
  logic                  wr_msts;
  logic                  key_ok;
  logic                  cmd_go;
  logic                  op_start;
  logic                  tmr_done;
  logic                  done_evt;

  // Write decode
  assign wr_target = bus_req_in.wr & fcs_hit(bus_req_in.addr, `FCS_OFF_TARGET);
  assign wr_word   = bus_req_in.wr & fcs_hit(bus_req_in.addr, `FCS_OFF_WORD);
  assign wr_cmd    = bus_req_in.wr & fcs_hit(bus_req_in.addr, `FCS_OFF_CMD);
  assign wr_mask   = bus_req_in.wr & fcs_hit(bus_req_in.addr, `FCS_OFF_MASK);
  assign wr_msts   = bus_req_in.wr & fcs_hit(bus_req_in.addr, `FCS_OFF_MSTS);

  // Keyed command acceptance; a busy sequencer drops the write so the running op is safe
  assign key_ok   = bus_req_in.wdata[`FCS_KEY_HI:`FCS_KEY_LO] == `FCS_KEY;
  assign cmd_go   = wr_cmd & key_ok & (state_q == FCS_IDLE);
  assign new_op   = fcs_pick(bus_req_in.wdata[`FCS_CMD_W-1:0]);
  assign op_start = cmd_go & (new_op != FCS_OP_NONE);

  // Length of the operation about to start
  assign op_len = (new_op == FCS_OP_COMMIT) ? COMMIT_CYCLES :
                  (new_op == FCS_OP_MASS)   ? MASS_CYCLES :
                  (new_op == FCS_OP_PAGE)   ? PAGE_CYCLES :
                                              WORD_CYCLES;

  fcs_op_timer u_timer (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (op_start),
    .len_in     (op_len),
    .done_out   (tmr_done)
  );

  // Sequencer: idle until a keyed command, busy until the timer ends
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FCS_IDLE:
        if (op_start)
          state_d = FCS_BUSY;
      FCS_BUSY:
        if (tmr_done)
          state_d = FCS_IDLE;
      default:
        state_d = FCS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      state_q <= FCS_IDLE;
    else
      state_q <= state_d;
  end

  // Operation kind and length held for the whole run
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      kind_q    <= FCS_OP_NONE;
      cur_len_q <= '0;
    end
    else if (op_start)
    begin
      kind_q    <= new_op;
      cur_len_q <= op_len;
    end
    else if (tmr_done)
      kind_q <= FCS_OP_NONE;
  end

  // Target location and data word; software may load the next pair during a run
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      target_q <= '0;
      word_q   <= '0;
    end
    else
    begin
      if (wr_target)
        target_q <= bus_req_in.wdata[`FCS_TGT_W-1:0];
      if (wr_word)
        word_q <= bus_req_in.wdata;
    end
  end

  // Operation seen by the array, captured at start so later writes cannot disturb it
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      op_q <= '0;
    else if (op_start)
      op_q <= '{busy: 1'b1, kind: new_op, target: target_q, word: word_q};
    else if (tmr_done)
      op_q <= '0;
  end

  // Busy readback per command bit
  assign cmd_busy[`FCS_CMD_WORD]   = kind_q == FCS_OP_WORD;
  assign cmd_busy[`FCS_CMD_PAGE]   = kind_q == FCS_OP_PAGE;
  assign cmd_busy[`FCS_CMD_MASS]   = kind_q == FCS_OP_MASS;
  assign cmd_busy[`FCS_CMD_COMMIT] = kind_q == FCS_OP_COMMIT;

  // Completion only for program and erase; a commit is not a programming cycle
  assign done_evt = tmr_done & (kind_q != FCS_OP_COMMIT);

  assign evt_set[`FCS_EVT_DONE] = done_evt;
  assign evt_set[`FCS_EVT_VIOL] = access_violation_in;
  assign evt_clr = wr_msts ? bus_req_in.wdata[`FCS_EVT_W-1:0] : '0;

  // Raw event flags, latched until cleared through the masked status register
  genvar gi;
  generate
    for (gi = 0; gi < `FCS_EVT_W; gi++)
    begin : g_evt
      fcs_event_flag u_flag (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (evt_set[gi]),
        .clr_in     (evt_clr[gi]),
        .flag_out   (raw_flags[gi])
      );
    end
  endgenerate

  // Interrupt mask
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      mask_q <= '0;
    else if (wr_mask)
      mask_q <= bus_req_in.wdata[`FCS_EVT_W-1:0];
  end

  // Read select; key field and reserved bits read as zero, unmapped reads as zero
  assign rd_d = fcs_hit(bus_req_in.addr, `FCS_OFF_TARGET) ? {{(`FCS_DW-`FCS_TGT_W){1'b0}}, target_q} :
                fcs_hit(bus_req_in.addr, `FCS_OFF_WORD)   ? word_q :
                fcs_hit(bus_req_in.addr, `FCS_OFF_CMD)    ? {{(`FCS_DW-`FCS_CMD_W){1'b0}}, cmd_busy} :
                fcs_hit(bus_req_in.addr, `FCS_OFF_RAW)    ? {{(`FCS_DW-`FCS_EVT_W){1'b0}}, raw_flags} :
                fcs_hit(bus_req_in.addr, `FCS_OFF_MASK)   ? {{(`FCS_DW-`FCS_EVT_W){1'b0}}, mask_q} :
                fcs_hit(bus_req_in.addr, `FCS_OFF_MSTS)   ? {{(`FCS_DW-`FCS_EVT_W){1'b0}}, raw_flags & mask_q} :
                                                            '0;

  // Read data for one cycle only, interrupt from the masked flags
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_q <= '0;
      irq_q     <= 1'b0;
    end
    else
    begin
      rd_data_q <= bus_req_in.rd ? rd_d : '0;
      irq_q     <= |(raw_flags & mask_q);
    end
  end

  assign rd_data_out  = rd_data_q;
  assign flash_op_out = op_q;
  assign irq_out      = irq_q;

  // Cycles spent busy, read only by the checks below
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      busy_cnt_q <= '0;
    else if (op_start)
      busy_cnt_q <= '0;
    else if (state_q == FCS_BUSY)
      busy_cnt_q <= busy_cnt_q + `FCS_CNT_ONE;
  end

  // Checks
  a_bad_key_ignored: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_cmd && !key_ok && state_q == FCS_IDLE) |=> (state_q == FCS_IDLE && kind_q == FCS_OP_NONE))
    else $error("command with wrong key started an operation");

  a_key_reads_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_req_in.rd && fcs_hit(bus_req_in.addr, `FCS_OFF_CMD)) |=> (rd_data_out[`FCS_KEY_HI:`FCS_KEY_LO] == '0))
    else $error("key field read back nonzero");

  a_zero_no_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && bus_req_in.wdata[`FCS_CMD_W-1:0] == '0) |=> (state_q == FCS_IDLE))
    else $error("command of zeros started an operation");

  a_good_key_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_go && bus_req_in.wdata[`FCS_CMD_WORD]) |=> (flash_op_out.busy && flash_op_out.kind == FCS_OP_WORD))
    else $error("keyed word program did not start");

  a_op_duration: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tmr_done |-> (busy_cnt_q == cur_len_q - `FCS_CNT_ONE) && (state_q == FCS_BUSY))
    else $error("operation ended at the wrong cycle");

  a_commit_busy_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_req_in.rd && fcs_hit(bus_req_in.addr, `FCS_OFF_CMD))
      |=> (rd_data_out[`FCS_CMD_COMMIT] == ($past(flash_op_out.kind) == FCS_OP_COMMIT)))
    else $error("commit busy bit wrong");

  a_mass_busy_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_req_in.rd && fcs_hit(bus_req_in.addr, `FCS_OFF_CMD))
      |=> (rd_data_out[`FCS_CMD_MASS] == ($past(flash_op_out.kind) == FCS_OP_MASS)))
    else $error("full erase busy bit wrong");

  a_page_busy_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_req_in.rd && fcs_hit(bus_req_in.addr, `FCS_OFF_CMD))
      |=> (rd_data_out[`FCS_CMD_PAGE] == ($past(flash_op_out.kind) == FCS_OP_PAGE)))
    else $error("page erase busy bit wrong");

  a_word_busy_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_req_in.rd && fcs_hit(bus_req_in.addr, `FCS_OFF_CMD))
      |=> (rd_data_out[`FCS_CMD_WORD] == ($past(flash_op_out.kind) == FCS_OP_WORD)))
    else $error("word program busy bit wrong");

  a_done_sets_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tmr_done && kind_q != FCS_OP_COMMIT) |=> raw_flags[`FCS_EVT_DONE])
    else $error("completion flag not set");

  a_viol_sets_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    access_violation_in |=> raw_flags[`FCS_EVT_VIOL])
    else $error("violation flag not set");

  a_irq_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mask_q == '0) |=> !irq_out)
    else $error("interrupt raised while all events masked");

  a_clear_both: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_msts && bus_req_in.wdata[`FCS_EVT_DONE] && !done_evt) |=> !raw_flags[`FCS_EVT_DONE])
    else $error("completion flag not cleared");

  a_busy_holds_op: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_q == FCS_BUSY && !tmr_done) |=> $stable(flash_op_out))
    else $error("running operation disturbed");

  c_word_done: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    tmr_done && kind_q == FCS_OP_WORD);
  c_commit_done: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    tmr_done && kind_q == FCS_OP_COMMIT);
  c_viol_irq: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    access_violation_in ##1 raw_flags[`FCS_EVT_VIOL] ##1 irq_out);
  c_busy_reject: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_cmd && key_ok && state_q == FCS_BUSY);

endmodule

// [testbench/test_fcs_command_status.sv]
// Self-checking bench for the flash command and status unit: register port, commands, events, interrupt.
// Assumes the package, fcs_consts.svh and the design files are compiled before it.
`timescale 1ns/1ps
`include "fcs_consts.svh"

module test_fcs_command_status
  import fcs_pkg::*;
;
  // Short operation lengths keep the run brief; all timing checks derive from these
  localparam logic [31:0] W_LEN = 32'h00000004;
  localparam logic [31:0] P_LEN = 32'h00000006;
  localparam logic [31:0] M_LEN = 32'h00000007;
  localparam logic [31:0] C_LEN = 32'h00000005;

  logic          clk_in;
  logic          sys_rst_in;
  fcs_bus_req_t  bus_req;
  logic [31:0]   rd_data;
  logic          viol;
  fcs_flash_op_t flash_op;
  logic          irq;
  int            n_errors;
  int            compares;
  fcs_op_t       kinds [4] = '{FCS_OP_WORD, FCS_OP_PAGE, FCS_OP_MASS, FCS_OP_COMMIT};
  logic [31:0]   lens  [4] = '{W_LEN, P_LEN, M_LEN, C_LEN};

  fcs_command_status #(
    .WORD_CYCLES   (W_LEN),
    .COMMIT_CYCLES (C_LEN),
    .PAGE_CYCLES   (P_LEN),
    .MASS_CYCLES   (M_LEN)
  ) uut (
    .clk_in              (clk_in),
    .sys_rst_in          (sys_rst_in),
    .bus_req_in          (bus_req),
    .rd_data_out         (rd_data),
    .access_violation_in (viol),
    .flash_op_out        (flash_op),
    .irq_out             (irq)
  );

  // Free-running 250 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Compare a multi-bit result
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t ns: value %0h, expected %0h", $time, got, exp);
    end
  endtask

  // Compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t ns: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; returns just after the edge that takes it
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_req <= '0;
    #1;
  endtask

  // One-cycle read strobe; data stands only in the following cycle, so sample there
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    bus_req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_req <= '0;
    #1;
    chk_val({32'h00000000, rd_data}, {32'h00000000, exp});
  endtask

  // Let a given number of edges pass, then settle
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Start one command, check its busy window, length, completion event and clear
  task automatic run_cmd(input int b, input bit poke);
    logic [31:0] tgt;
    time         t0;
    int          k;
    tgt = 32'h00000400 * (b + 1);
    bus_wr(`FCS_OFF_TARGET, tgt);
    bus_wr(`FCS_OFF_WORD, 32'hC0DE0000 | b);
    bus_wr(`FCS_OFF_CMD, {`FCS_KEY, 16'h0001 << b});
    t0 = $time;
    chk_bit(flash_op.busy, 1'b1);
    chk_val({61'h0, flash_op.kind}, {61'h0, kinds[b]});
    chk_val({49'h0, flash_op.target}, {49'h0, tgt[14:0]});
    chk_val({32'h0, flash_op.word}, {32'h0, 32'hC0DE0000 | b});
    rd_chk(`FCS_OFF_CMD, 32'h00000001 << b);
    // A second command while busy must be dropped, so the kind must not change
    if (poke)
    begin
      bus_wr(`FCS_OFF_CMD, {`FCS_KEY, 16'h0001});
      chk_val({61'h0, flash_op.kind}, {61'h0, kinds[b]});
    end
    k = 0;
    while (flash_op.busy === 1'b1 && k < 200)
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    chk_val(($time - t0) / 4, {32'h0, lens[b]});
    idle(3);
    chk_bit(flash_op.busy, 1'b0);
    rd_chk(`FCS_OFF_CMD, 32'h00000000);
    rd_chk(`FCS_OFF_RAW, (b < 3) ? 32'h00000002 : 32'h00000000);
    chk_bit(irq, b < 3);
    bus_wr(`FCS_OFF_MSTS, 32'h00000002);
    idle(1);
    chk_bit(irq, 1'b0);
    rd_chk(`FCS_OFF_RAW, 32'h00000000);
  endtask

  // Verdict in one place, used by the main sequence and the watchdog
  task automatic wrap_up;
    $display("errors %0d, comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    #20000;
    n_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    wrap_up;
  end

  // Main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    bus_req    = '0;
    viol       = 1'b0;
    n_errors   = 0;
    compares   = 0;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk_val({13'h0, flash_op}, 64'h0);
    chk_bit(irq, 1'b0);
    // Every mapped register reads zero out of reset, and one unmapped place too
    for (int a = 0; a <= 24; a += 4)
      rd_chk(a[11:0], 32'h00000000);
    bus_wr(12'h018, 32'hFFFFFFFF);
    rd_chk(12'h018, 32'h00000000);
    bus_wr(`FCS_OFF_TARGET, 32'hFFFFFFFF);
    rd_chk(`FCS_OFF_TARGET, 32'h00007FFF);
    // Wrong key, then right key with no command bit: neither may start anything
    bus_wr(`FCS_OFF_CMD, 32'h1234000F);
    idle(1);
    chk_bit(flash_op.busy, 1'b0);
    rd_chk(`FCS_OFF_CMD, 32'h00000000);
    bus_wr(`FCS_OFF_CMD, {`FCS_KEY, 16'h0000});
    idle(1);
    chk_bit(flash_op.busy, 1'b0);
    // Violation event while masked: recorded, latched, but no interrupt
    @(posedge clk_in);
    viol <= 1'b1;
    @(posedge clk_in);
    viol <= 1'b0;
    idle(3);
    chk_bit(irq, 1'b0);
    rd_chk(`FCS_OFF_RAW, 32'h00000001);
    rd_chk(`FCS_OFF_MSTS, 32'h00000000);
    bus_wr(`FCS_OFF_MASK, 32'h00000001);
    idle(1);
    chk_bit(irq, 1'b1);
    rd_chk(`FCS_OFF_MSTS, 32'h00000001);
    bus_wr(`FCS_OFF_MSTS, 32'h00000001);
    idle(1);
    chk_bit(irq, 1'b0);
    rd_chk(`FCS_OFF_RAW, 32'h00000000);
    // Unmasked violation: interrupt follows the flag by one cycle
    @(posedge clk_in);
    viol <= 1'b1;
    @(posedge clk_in);
    viol <= 1'b0;
    idle(1);
    chk_bit(irq, 1'b1);
    bus_wr(`FCS_OFF_MSTS, 32'h00000001);
    idle(1);
    chk_bit(irq, 1'b0);
    // Completion interrupt enabled for the command runs
    bus_wr(`FCS_OFF_MASK, 32'h00000002);
    rd_chk(`FCS_OFF_MASK, 32'h00000002);
    for (int b = 0; b < 4; b++)
      run_cmd(b, b != 0);
    wrap_up;
  end
endmodule
